// [pkg/blrb_pkg.sv]
// shared constants and types of the backlight host register bank
package blrb_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_BRT = 8'h00;
    localparam logic [7:0] OFS_CUR = 8'h02;
    localparam logic [7:0] OFS_CFG1 = 8'h04;
    localparam logic [7:0] OFS_CFG2 = 8'h06;
    localparam logic [7:0] OFS_EN_SUP = 8'h08;
    localparam logic [7:0] OFS_EN_BST = 8'h0A;
    localparam logic [7:0] OFS_EN_STR = 8'h0C;
    localparam logic [7:0] OFS_FL_SUP = 8'h0E;
    localparam logic [7:0] OFS_FL_BST = 8'h10;
    localparam logic [7:0] OFS_FL_STR = 8'h12;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_IN_DUTY = 8'h16;
    localparam logic [7:0] OFS_OUT_DUTY = 8'h18;
    localparam logic [7:0] OFS_DAC = 8'h1A;
    localparam logic [7:0] OFS_BOOST = 8'h1C;
    localparam logic [7:0] OFS_AUTO = 8'h1E;
    localparam logic [7:0] OFS_LAST = 8'h1E;

    // ==========================================================
    // reset values
    localparam logic [15:0] RST_BRT = 16'h0000;
    localparam logic [11:0] RST_CUR = 12'hFFF;
    localparam logic [15:0] RST_CFG1 = 16'h08A3;
    localparam logic [15:0] RST_CFG2 = 16'h0000;
    localparam logic [7:0] RST_EN = 8'hFF;

    // ==========================================================
    // field positions of the first user settings register
    localparam int CFG1_PSEUDO_BIT = 14;
    localparam int CFG1_RATE_LSB = 12;
    localparam int CFG1_RANGE_LSB = 10;
    localparam int CFG1_SRC_LSB = 8;
    localparam int CFG1_SLOPE_LSB = 5;
    localparam int CFG1_DITHER_LSB = 2;
    localparam int CFG1_SMOOTH_BIT = 1;
    localparam logic [1:0] SRC_REGISTER = 2'h2;

    // ==========================================================
    // alert enable field codes and fault slots
    localparam logic [1:0] EN_WR_OFF = 2'h1;
    localparam logic [1:0] EN_WR_ON = 2'h3;
    localparam logic [1:0] EN_RD_ON = 2'h2;
    localparam int NFLT = 8;
    localparam int GLOBAL_SLOT = 0;
    localparam int SERIAL_ERR_SLOT = 7;

    // ==========================================================
    // serial addresses and timing
    localparam logic [6:0] ADDR_LOW = 7'h2A;
    localparam logic [6:0] ADDR_HIGH = 7'h2B;
    localparam int CLK_MHZ = 250;
    localparam int TIMEOUT_MS = 500;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_OFFS, PH_WHI, PH_WLO, PH_RHI, PH_RLO, PH_IGN
    } blrb_phase_e;

    typedef logic [2:0][NFLT-1:0] blrb_fgrp_t;

    typedef struct packed {
        logic [3:0] state_code;
        logic [15:0] input_duty;
        logic [15:0] output_duty;
        logic [11:0] dac_code;
        logic [9:0] boost_target;
        logic [1:0] dim_mode;
        logic [3:0] phase_layout;
        logic [3:0] switch_rate;
        logic [3:0] pwm_rate;
    } blrb_diag_s;

    typedef struct packed {
        logic [15:0] brightness_value;
        logic [11:0] drive_current_code;
        logic pseudo_random_on;
        logic [1:0] spectrum_spread_rate;
        logic [1:0] spread_range;
        logic [1:0] brightness_source_select;
        logic [2:0] slope_time;
        logic [2:0] dither_bits;
        logic s_curve_smoothing_on;
        logic [15:0] user_two;
    } blrb_cfg_s;

endpackage

// [core/blrb_link.sv]
// serial clock domain capture of the data line
`timescale 1ns/1ns
`default_nettype none
module blrb_link (
    input wire logic link_clk, // serial clock pin, clocks this module
    input wire logic rst, // asynchronous reset, active high
    input wire logic sda_i, // serial data pin level
    output logic bit_o, // last data bit taken on a rising clock
    output logic tog_o // flips once for every bit taken
);
    typedef struct packed {
        logic bit_v;
        logic tog;
    } blrb_link_s;

    blrb_link_s r;
    blrb_link_s nxt;

    // ==========================================================
    // take a bit on each rising serial clock and flag it by toggle
    always_comb begin
        nxt = r;
        nxt.bit_v = sda_i;
        nxt.tog = ~r.tog;
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign bit_o = r.bit_v;
    assign tog_o = r.tog;
endmodule
`default_nettype wire

// [core/blrb_regs.sv]
// host register bank with serial slave and fault alert
// Notes on behaviour
// - without any serial access, pins and detected settings drive the device fully.
// - alert output asserts whenever an enabled fault is latched while the global enable is set.
// - fault flag clears only when status and clear bits are both written 1.
// - enable field reads 2'b10 when that fault drives the alert.
// - writing 2'b01 disables, 2'b11 enables a fault's alert.
// - global enable cleared blocks every fault from the alert.
// - status flags sit in three registers: supply, boost, LED strings.
// - offset 00h holds 16-bit brightness, reset zero, used under register control.
// - current register holds 12-bit code in bits 11-0, reset FFFh.
// - read-only 16-bit measured input PWM duty.
// - read-only 16-bit commanded output PWM duty.
// - read-only 12-bit applied current DAC code.
// - read-only 10-bit adaptive boost target code.
// - read-only present state machine state.
// - read-only detected dimming mode, phase layout, switch and PWM rates.
// - configuration field selects up to 3 bits of PWM dither.
// - source select picks measured PWM input or brightness register.
// - two 2-bit fields set spread range and spread modulation rate.
// - one bit switches spread modulation to pseudo-random.
// - one bit enables S-curve smoothing; a field sets ramp duration.
// - write is address+W, offset, then two data bytes.
// - read is address+W, offset, address+R, then two returned bytes.
// - device answers address 0x2A or 0x2B chosen by the strap.
// - command without stop for 500ms sets serial error and alert.
`timescale 1ns/1ns
`default_nettype none
module blrb_regs #(
    parameter int unsigned TIMEOUT_CYCLES = blrb_pkg::TIMEOUT_CYC
) (
    input wire logic clk_sys, // core clock, 250 MHz
    input wire logic rst, // asynchronous reset, active high
    input wire logic link_clk, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data drive level, always low
    output logic sda_oe_n, // serial data drive enable, low drives
    output logic alert_o, // alert pin drive level, always low
    output logic alert_oe_n, // alert pin drive enable, low asserts alert
    input wire logic addr_sel, // detected address strap, 1 selects high address
    input wire blrb_pkg::blrb_fgrp_t fault_i, // fault event pulses per group
    input wire blrb_pkg::blrb_diag_s diag_i, // live diagnostic values
    output blrb_pkg::blrb_cfg_s cfg_o // settings toward the datapath
);
    typedef struct packed {
        logic scl_a, scl_b, scl_c;
        logic sda_a, sda_b, sda_c;
        logic tog_a, tog_b, tog_c;
        blrb_pkg::blrb_phase_e ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] offs;
        logic [7:0] hold;
        logic [7:0] tx;
        logic ack;
        logic [26:0] tmo;
        logic [15:0] brt;
        logic [11:0] cur;
        logic [15:0] cfg1;
        logic [15:0] cfg2;
        blrb_pkg::blrb_fgrp_t en;
        blrb_pkg::blrb_fgrp_t fl;
        logic [15:0] bval;
        logic sda_oe_n;
        logic alert_oe_n;
    } blrb_regs_s;

    blrb_regs_s r;
    blrb_regs_s nxt;
    logic link_bit;
    logic link_tog;
    logic bit_ev;
    logic fall;
    logic start;
    logic stop;
    logic wr_go;
    logic [15:0] wdata;
    logic [7:0] byte_in;
    logic [6:0] my_addr;
    blrb_pkg::blrb_fgrp_t en_eff;
    logic [15:0] rword;

    // ==========================================================
    // decoding helpers
    function automatic logic reg_hit(input logic [7:0] ofs);
        reg_hit = (ofs <= blrb_pkg::OFS_LAST) && !ofs[0];
    endfunction

    function automatic logic [15:0] pack_en(input logic [7:0] e);
        logic [15:0] w;
        w = '0;
        for (int k = 0; k < blrb_pkg::NFLT; k++) begin
            w[2*k +: 2] = e[k] ? blrb_pkg::EN_RD_ON : 2'h0;
        end
        pack_en = w;
    endfunction

    function automatic logic [15:0] pack_fl(input logic [7:0] f);
        logic [15:0] w;
        w = '0;
        for (int k = 0; k < blrb_pkg::NFLT; k++) begin
            w[2*k+1] = f[k]; // clear bit reads zero
        end
        pack_fl = w;
    endfunction

    function automatic logic [15:0] rd_word(input blrb_regs_s s, input blrb_pkg::blrb_diag_s d);
        logic [15:0] w;
        w = '0; // reserved bits and unmapped offsets read zero
        case (s.offs)
            blrb_pkg::OFS_BRT: w = s.brt;
            blrb_pkg::OFS_CUR: w = {4'h0, s.cur};
            blrb_pkg::OFS_CFG1: w = s.cfg1;
            blrb_pkg::OFS_CFG2: w = s.cfg2;
            blrb_pkg::OFS_EN_SUP: w = pack_en(s.en[0]);
            blrb_pkg::OFS_EN_BST: w = pack_en(s.en[1]);
            blrb_pkg::OFS_EN_STR: w = pack_en(s.en[2]);
            blrb_pkg::OFS_FL_SUP: w = pack_fl(s.fl[0]);
            blrb_pkg::OFS_FL_BST: w = pack_fl(s.fl[1]);
            blrb_pkg::OFS_FL_STR: w = pack_fl(s.fl[2]);
            blrb_pkg::OFS_STATE: w = {12'h000, d.state_code};
            blrb_pkg::OFS_IN_DUTY: w = d.input_duty;
            blrb_pkg::OFS_OUT_DUTY: w = d.output_duty;
            blrb_pkg::OFS_DAC: w = {4'h0, d.dac_code};
            blrb_pkg::OFS_BOOST: w = {6'h00, d.boost_target};
            blrb_pkg::OFS_AUTO: begin
                w = {2'h0, d.dim_mode, d.phase_layout, d.switch_rate, d.pwm_rate};
            end
            default: w = '0;
        endcase
        rd_word = w;
    endfunction

    // ==========================================================
    // serial clock domain bit capture
    blrb_link u_link (
        .link_clk(link_clk),
        .rst(rst),
        .sda_i(sda_i),
        .bit_o(link_bit),
        .tog_o(link_tog)
    );

    // ==========================================================
    // pin events seen in the core domain
    assign bit_ev = r.tog_b ^ r.tog_c;
    assign fall = r.scl_c & ~r.scl_b;
    assign start = r.scl_b & r.scl_c & r.sda_c & ~r.sda_b;
    assign stop = r.scl_b & r.scl_c & ~r.sda_c & r.sda_b;
    assign byte_in = {r.sh[6:0], link_bit};
    assign my_addr = addr_sel ? blrb_pkg::ADDR_HIGH : blrb_pkg::ADDR_LOW;
    assign wr_go = bit_ev && (r.cnt == 4'h7) && (r.ph == blrb_pkg::PH_WLO);
    assign wdata = {r.hold, byte_in}; // high byte came first
    assign rword = rd_word(r, diag_i); // readable word at the latched offset

    // global slot gates rather than reports
    always_comb begin
        en_eff = r.en;
        en_eff[0][blrb_pkg::GLOBAL_SLOT] = 1'b0;
    end

    // ==========================================================
    // next state: serial engine, registers, flags, alert
    always_comb begin
        nxt = r;
        nxt.scl_a = link_clk;
        nxt.scl_b = r.scl_a;
        nxt.scl_c = r.scl_b;
        nxt.sda_a = sda_i;
        nxt.sda_b = r.sda_a;
        nxt.sda_c = r.sda_b;
        nxt.tog_a = link_tog;
        nxt.tog_b = r.tog_a;
        nxt.tog_c = r.tog_b;

        // transaction watchdog
        if (r.ph != blrb_pkg::PH_IDLE) begin
            nxt.tmo = r.tmo + 27'h0000001;
        end

        // byte framing
        if (bit_ev) begin
            if (r.cnt != 4'h8) begin
                nxt.sh = byte_in;
                nxt.cnt = r.cnt + 4'h1;
                if (r.ph == blrb_pkg::PH_RHI || r.ph == blrb_pkg::PH_RLO) begin
                    nxt.tx = {r.tx[6:0], 1'b1};
                end
                if (r.cnt == 4'h7) begin
                    nxt.ack = 1'b1;
                    case (r.ph)
                        blrb_pkg::PH_ADDR: begin
                            if (byte_in[7:1] != my_addr) begin
                                nxt.ack = 1'b0;
                                nxt.ph = blrb_pkg::PH_IGN;
                            end else if (byte_in[0]) begin
                                nxt.ph = blrb_pkg::PH_RHI;
                                nxt.tx = rword[15:8];
                                nxt.hold = rword[7:0];
                            end else begin
                                nxt.ph = blrb_pkg::PH_OFFS;
                            end
                        end
                        blrb_pkg::PH_OFFS: begin
                            nxt.offs = byte_in;
                            nxt.ph = blrb_pkg::PH_WHI;
                        end
                        blrb_pkg::PH_WHI: begin
                            nxt.hold = byte_in;
                            nxt.ph = blrb_pkg::PH_WLO;
                        end
                        blrb_pkg::PH_WLO: begin
                            nxt.ph = blrb_pkg::PH_IGN;
                        end
                        default: nxt.ack = 1'b0;
                    endcase
                end
            end else begin
                nxt.cnt = 4'h0;
                nxt.ack = 1'b0;
                if (r.ack) begin
                    nxt.ph = r.ph; // own acknowledge slot: read data has not begun yet
                end else if (r.ph == blrb_pkg::PH_RHI && !link_bit) begin
                    nxt.ph = blrb_pkg::PH_RLO;
                    nxt.tx = r.hold;
                end else if (r.ph == blrb_pkg::PH_RHI || r.ph == blrb_pkg::PH_RLO) begin
                    nxt.ph = blrb_pkg::PH_IGN;
                end
            end
        end

        // data line drive, changed only while the clock is low
        if (fall) begin
            if (r.cnt == 4'h8) begin
                nxt.sda_oe_n = ~r.ack;
            end else if (r.ph == blrb_pkg::PH_RHI || r.ph == blrb_pkg::PH_RLO) begin
                nxt.sda_oe_n = r.tx[7];
            end else begin
                nxt.sda_oe_n = 1'b1;
            end
        end

        // register writes; read-only and unmapped offsets ignored
        if (wr_go && reg_hit(r.offs)) begin
            case (r.offs)
                blrb_pkg::OFS_BRT: nxt.brt = wdata;
                blrb_pkg::OFS_CUR: nxt.cur = wdata[11:0];
                blrb_pkg::OFS_CFG1: nxt.cfg1 = wdata;
                blrb_pkg::OFS_CFG2: nxt.cfg2 = wdata;
                blrb_pkg::OFS_EN_SUP, blrb_pkg::OFS_EN_BST, blrb_pkg::OFS_EN_STR: begin
                    for (int k = 0; k < blrb_pkg::NFLT; k++) begin
                        for (int g = 0; g < 3; g++) begin
                            if (r.offs == blrb_pkg::OFS_EN_SUP + 8'(2 * g)) begin
                                if (wdata[2*k +: 2] == blrb_pkg::EN_WR_OFF) begin
                                    nxt.en[g][k] = 1'b0;
                                end else if (wdata[2*k +: 2] == blrb_pkg::EN_WR_ON) begin
                                    nxt.en[g][k] = 1'b1;
                                end
                            end
                        end
                    end
                end
                blrb_pkg::OFS_FL_SUP, blrb_pkg::OFS_FL_BST, blrb_pkg::OFS_FL_STR: begin
                    for (int k = 0; k < blrb_pkg::NFLT; k++) begin
                        for (int g = 0; g < 3; g++) begin
                            if (r.offs == blrb_pkg::OFS_FL_SUP + 8'(2 * g)) begin
                                if (wdata[2*k +: 2] == 2'h3) begin
                                    nxt.fl[g][k] = 1'b0;
                                end
                            end
                        end
                    end
                end
                default: nxt.brt = r.brt; // read-only
            endcase
        end

        // new fault events win over a clear in the same cycle
        nxt.fl = nxt.fl | fault_i;

        // start, stop and watchdog override the framing
        if (start) begin
            nxt.ph = blrb_pkg::PH_ADDR;
            nxt.cnt = 4'h0;
            nxt.ack = 1'b0;
            nxt.tmo = '0;
            nxt.sda_oe_n = 1'b1;
        end else if (stop) begin
            nxt.ph = blrb_pkg::PH_IDLE;
            nxt.tmo = '0;
            nxt.sda_oe_n = 1'b1;
        end else if (r.ph != blrb_pkg::PH_IDLE && r.tmo >= 27'(TIMEOUT_CYCLES - 1)) begin
            nxt.ph = blrb_pkg::PH_IDLE;
            nxt.tmo = '0;
            nxt.sda_oe_n = 1'b1;
            nxt.fl[0][blrb_pkg::SERIAL_ERR_SLOT] = 1'b1;
        end

        // alert pin and brightness source
        nxt.alert_oe_n = ~(r.en[0][blrb_pkg::GLOBAL_SLOT] && |(r.fl & en_eff));
        if (r.cfg1[blrb_pkg::CFG1_SRC_LSB +: 2] == blrb_pkg::SRC_REGISTER) begin
            nxt.bval = r.brt;
        end else begin
            nxt.bval = diag_i.input_duty; // pin control needs no access
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r <= '{ph: blrb_pkg::PH_IDLE, brt: blrb_pkg::RST_BRT, cur: blrb_pkg::RST_CUR,
                cfg1: blrb_pkg::RST_CFG1, cfg2: blrb_pkg::RST_CFG2,
                en: {3{blrb_pkg::RST_EN}}, sda_oe_n: 1'b1, alert_oe_n: 1'b1, default: '0};
        end else begin
            r <= nxt;
        end
    end

    // ==========================================================
    // outputs, all from flops
    assign sda_o = 1'b0 & r.sda_oe_n;
    assign sda_oe_n = r.sda_oe_n;
    assign alert_o = 1'b0 & r.alert_oe_n;
    assign alert_oe_n = r.alert_oe_n;
    assign cfg_o = '{brightness_value: r.bval, drive_current_code: r.cur,
        pseudo_random_on: r.cfg1[blrb_pkg::CFG1_PSEUDO_BIT],
        spectrum_spread_rate: r.cfg1[blrb_pkg::CFG1_RATE_LSB +: 2],
        spread_range: r.cfg1[blrb_pkg::CFG1_RANGE_LSB +: 2],
        brightness_source_select: r.cfg1[blrb_pkg::CFG1_SRC_LSB +: 2],
        slope_time: r.cfg1[blrb_pkg::CFG1_SLOPE_LSB +: 3],
        dither_bits: r.cfg1[blrb_pkg::CFG1_DITHER_LSB +: 3],
        s_curve_smoothing_on: r.cfg1[blrb_pkg::CFG1_SMOOTH_BIT], user_two: r.cfg2};

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_addr_byte;
        bit_ev && r.cnt == 4'h7 && r.ph == blrb_pkg::PH_ADDR && byte_in[7:1] == my_addr;
    endsequence
    sequence s_acked;
        r.ack && r.cnt == 4'h8 && r.ph != blrb_pkg::PH_IGN;
    endsequence

    property p_addr_ack;
        s_addr_byte |=> s_acked;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged");

    property p_global_off;
        !r.en[0][blrb_pkg::GLOBAL_SLOT] |=> alert_oe_n;
    endproperty
    a_global_off: assert property (p_global_off) else $error("alert despite global off");

    property p_alert_on;
        r.en[0][blrb_pkg::GLOBAL_SLOT] && |(r.fl & en_eff) |=> !alert_oe_n;
    endproperty
    a_alert_on: assert property (p_alert_on) else $error("enabled fault gave no alert");

    property p_clear;
        wr_go && r.offs == blrb_pkg::OFS_FL_BST && wdata[7:6] == 2'h3 && !fault_i[1][3]
            |=> !r.fl[1][3];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");
    property p_half_clear;
        r.fl[1][3] && !(wr_go && r.offs == blrb_pkg::OFS_FL_BST && wdata[7:6] == 2'h3)
            |=> r.fl[1][3];
    endproperty
    a_half_clear: assert property (p_half_clear) else $error("flag lost without clear");
    property p_en_write;
        wr_go && r.offs == blrb_pkg::OFS_EN_BST && wdata[7:6] == blrb_pkg::EN_WR_OFF
            |=> !r.en[1][3] ##1 (pack_en(r.en[1]) & 16'h00C0) == 16'h0000;
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable field not cleared");

    property p_brt_write;
        wr_go && r.offs == blrb_pkg::OFS_BRT |=> r.brt == $past(wdata);
    endproperty
    a_brt_write: assert property (p_brt_write) else $error("brightness write lost");

    property p_ro_write;
        wr_go && r.offs >= blrb_pkg::OFS_STATE |=> $stable(r.brt) && $stable(r.cfg1);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write took effect");

    property p_source;
        r.cfg1[blrb_pkg::CFG1_SRC_LSB +: 2] == blrb_pkg::SRC_REGISTER |=> r.bval == $past(r.brt);
    endproperty
    a_source: assert property (p_source) else $error("brightness source wrong");

    property p_timeout;
        r.ph != blrb_pkg::PH_IDLE && r.tmo >= 27'(TIMEOUT_CYCLES - 1) && !start && !stop
            |=> r.ph == blrb_pkg::PH_IDLE && r.fl[0][blrb_pkg::SERIAL_ERR_SLOT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("serial timeout not flagged");
endmodule
`default_nettype wire

// [tb/blrb_host.sv]
// host serial controller model driving the link clock and the data line
`timescale 1ns/1ns
`default_nettype none
module blrb_host (
    output logic scl, // serial clock, still between frames
    output logic sdo, // data drive, 1 releases the line to the pull-up
    input wire logic sda // resolved data line
);
    logic [7:0] q;
    logic ak;
    initial begin
        scl = 1'b1;
        sdo = 1'b1;
    end
    // start or repeated start
    task st;
        sdo = 1'b1;
        #16 scl = 1'b1;
        #16 sdo = 1'b0;
        #16 scl = 1'b0;
    endtask
    task sp;
        sdo = 1'b0;
        #16 scl = 1'b1;
        #16 sdo = 1'b1;
        #16;
    endtask
    // one byte msb first, then the ninth bit; ak drops on any missing acknowledge
    task by(input logic [7:0] d, input logic m);
        for (int i = 8; i >= 0; i--) begin
            sdo = (i > 0) ? d[i-1] : m;
            #32 scl = 1'b1;
            #16 if (i > 0) q[i-1] = sda; else ak = ak & ~sda;
            #16 scl = 1'b0;
        end
    endtask
    // only even offsets up to 1Eh are ever written
    task wr(input logic [7:0] o, input logic [15:0] v);
        ak = 1'b1;
        st;
        by(8'h54, 1'b1);
        by(o, 1'b1);
        by(v[15:8], 1'b1);
        by(v[7:0], 1'b1);
        sp;
    endtask
    task rd(input logic [7:0] o, output logic [15:0] v);
        st;
        by(8'h54, 1'b1);
        by(o, 1'b1);
        st;
        by(8'h55, 1'b1);
        by(8'hFF, 1'b0);
        v[15:8] = q;
        by(8'hFF, 1'b1);
        v[7:0] = q;
        sp;
    endtask
endmodule
`default_nettype wire

// [tb/blrb_regs_bench.sv]
// self-checking bench of the backlight host register bank
`timescale 1ns/1ns
`default_nettype none
module blrb_regs_bench;
    logic clk_sys, rst, addr_sel, scl, sdo, sda_o, sda_oe_n, alert_o, alert_oe_n;
    blrb_pkg::blrb_fgrp_t fault_i;
    blrb_pkg::blrb_diag_s diag_i;
    blrb_pkg::blrb_cfg_s cfg_o;
    logic [15:0] v;
    int n_errors = 0;
    int n_checks = 0;
    wire sda;
    assign sda = sdo & sda_oe_n; // open drain with pull-up
    blrb_host h (.scl(scl), .sdo(sdo), .sda(sda));
    blrb_regs #(.TIMEOUT_CYCLES(2000)) DUT (.clk_sys(clk_sys), .rst(rst), .link_clk(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .alert_o(alert_o),
        .alert_oe_n(alert_oe_n), .addr_sel(addr_sel), .fault_i(fault_i), .diag_i(diag_i),
        .cfg_o(cfg_o));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task ck(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task rdck(input string n, input logic [7:0] o, input logic [15:0] e);
        h.rd(o, v);
        ck(n, e, v);
    endtask
    task wrk(input logic [7:0] o, input logic [15:0] d);
        h.wr(o, d);
        ck("write ack", 16'h0001, {15'h0000, h.ak});
    endtask
    task alert(input logic e);
        repeat (3) @(negedge clk_sys);
        ck("alert release", {15'h0000, e}, {15'h0000, alert_oe_n});
    endtask
    task pulse(input int g, input int k);
        @(negedge clk_sys);
        fault_i[g][k] = 1'b1;
        @(negedge clk_sys);
        fault_i = '0;
    endtask
    task t_reset;
        rdck("brightness", 8'h00, 16'h0000);
        rdck("current", 8'h02, 16'h0FFF);
        rdck("settings one", 8'h04, 16'h08A3);
        rdck("supply enables", 8'h08, 16'hAAAA);
        ck("pin brightness", 16'h1234, cfg_o.brightness_value);
        alert(1'b1);
        $display("reset values done");
    endtask
    task t_regs;
        wrk(8'h00, 16'hA55A);
        rdck("brightness", 8'h00, 16'hA55A);
        wrk(8'h04, 16'h0200);
        ck("register brightness", 16'hA55A, cfg_o.brightness_value);
        wrk(8'h02, 16'hFFFF);
        rdck("current", 8'h02, 16'h0FFF);
        wrk(8'h16, 16'h0000);
        rdck("input duty", 8'h16, 16'h1234);
        rdck("dac code", 8'h1A, 16'h05A5);
        rdck("state", 8'h14, 16'h0009);
        $display("register access done");
    endtask
    task t_addr;
        addr_sel = 1'b1;
        h.wr(8'h00, 16'h1111);
        ck("foreign address ack", 16'h0000, {15'h0000, h.ak});
        addr_sel = 1'b0;
        rdck("brightness kept", 8'h00, 16'hA55A);
        $display("address select done");
    endtask
    task t_fault;
        pulse(1, 3);
        alert(1'b0);
        rdck("boost flags", 8'h10, 16'h0080);
        wrk(8'h10, 16'h0080);
        rdck("flag kept", 8'h10, 16'h0080);
        wrk(8'h10, 16'h00C0);
        rdck("flag cleared", 8'h10, 16'h0000);
        alert(1'b1);
        wrk(8'h0A, 16'h0040);
        rdck("boost enables", 8'h0A, 16'hAA2A);
        pulse(1, 3);
        alert(1'b1);
        wrk(8'h0A, 16'h00C0);
        alert(1'b0);
        wrk(8'h08, 16'h0001);
        alert(1'b1);
        $display("fault alerts done");
    endtask
    task t_timeout;
        wrk(8'h10, 16'h00C0);
        wrk(8'h08, 16'h0003);
        alert(1'b1);
        h.st;
        h.by(8'h54, 1'b1);
        repeat (2100) @(negedge clk_sys);
        rdck("serial error", 8'h0E, 16'h8000);
        alert(1'b0);
        $display("serial timeout done");
    endtask
    initial begin
        rst = 1'b1;
        addr_sel = 1'b0;
        fault_i = '0;
        diag_i = '0;
        diag_i.input_duty = 16'h1234;
        diag_i.dac_code = 12'h5A5;
        diag_i.state_code = 4'h9; // a running state code, read back by the state check
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_reset;
        t_regs;
        t_addr;
        t_fault;
        t_timeout;
        results;
    end
    // hang guard
    initial begin
        #300000;
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
